// File: rtl/sclink_consts.svh
`ifndef SCLINK_CONSTS_SVH
`define SCLINK_CONSTS_SVH
`define SW1_NORMAL      8'h90
`define SW2_NORMAL      8'h00
`define IFS_DEFAULT     8'h20
`define IFS_MAX         8'hFE
`define LEN_RESERVED    8'hFF
`define BGT_ETU         16'h0016
`define CWT_BASE_ETU    16'h000B
`define CWI_MAX         4'h5
`define ERR_SAMPLE_HALF 16'h0015
`define ERR_TX_SAMPLE   16'h000B
`define REPEAT_GAP_ETU  16'h0002
`define ETU_DEFAULT     16'h0174
`define BWT_DEFAULT     16'h0F00
`define ADDR_OFS        5'h00
`define CTRL_OFS        5'h04
`define STAT_OFS        5'h08
`define CWI_OFS         5'h0C
`define CARD_MAX_INFO_LENGTH_OFS        5'h10
`define TXD_OFS         5'h14
`define RXD_OFS         5'h18
`define ETU_OFS         5'h1C
`endif

// File: rtl/sclink_etu_gen.sv
`timescale 1ns/100ps
`default_nettype none
`include "sclink_consts.svh"
module sclink_etu_gen (
  // Clock and reset
  input wire logic CLK,
  input wire logic SRST,
  input wire logic restart,
  // Tick outputs
  sclink_etu_if.gen etu
);
  logic [15:0] cnt_q;
  // Count card-clock cycles per etu; restart aligns to a start edge
  always_ff @(posedge CLK) begin
    if (SRST || restart || cnt_q + 16'h0001 >= etu.div) begin
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
  assign etu.tick = !restart && (cnt_q + 16'h0001 >= etu.div);
  assign etu.half = !restart && (cnt_q == {1'b0, etu.div[15:1]});
endmodule
`default_nettype wire

// File: rtl/sclink_etu_if.sv
`timescale 1ns/100ps
`default_nettype none
// Etu tick and half tick between the timing unit and the framer
interface sclink_etu_if;
  logic        tick;
  logic        half;
  logic [15:0] div;
  modport gen (input div, output tick, output half);
  modport use_ (output div, input tick, input half);
endinterface
`default_nettype wire

// File: rtl/sclink_pkg.sv
package sclink_pkg;
  typedef enum logic [2:0] {
    RX_NAD = 3'b000,
    RX_PCB = 3'b001,
    RX_LEN = 3'b010,
    RX_INF = 3'b011,
    RX_EDC = 3'b100
  } blk_e;
  typedef enum logic [1:0] {
    BT_INFO = 2'b00,
    BT_RDY  = 2'b01,
    BT_SUP  = 2'b10
  } btype_e;
endpackage

// File: rtl/sclink_top.sv
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "sclink_consts.svh"
module sclink_top (
  // Clock and reset
  input  wire logic       CLK,
  input  wire logic       SRST,
  // Register port
  input  wire logic [4:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  // I/O line, open drain
  input  wire logic       IO_IN,
  output logic            IO_OUT,
  output logic            IO_OE_N
);
  sclink_etu_if etu ();
  logic        restart;
  sclink_etu_gen sclink_etu_gen_inst (.CLK(CLK), .SRST(SRST), .restart(restart), .etu(etu));
  // Software state
  logic [15:0] etudiv_q;
  logic        blockmode_q, tx_busy_q;
  logic [7:0]  txd_q, rxd_q, card_max_info_length_q, addr_q, status_q;
  logic [3:0]  cwi_q;
  logic        rx_valid_q, rx_perr_q, edc_err_q, addr_err_q, cwt_err_q, len_err_q;
  logic        repeat_q;
  assign etu.div = etudiv_q;
  // Parity over a byte
  function automatic logic par8(input logic [7:0] b);
    par8 = ^b;
  endfunction
  // Receiver and transmitter share the half-duplex line
  typedef enum logic [1:0] {
    L_IDLE = 2'b00,
    L_RX   = 2'b01,
    L_TX   = 2'b10,
    L_GAP  = 2'b11
  } line_e;
  line_e       st_q;
  logic [15:0] hcnt_q;  // Half-etu count since start edge
  logic [9:0]  sh_q;
  logic        io_prev_q, err_drive_q, rx_last_q, tx_last_q;
  logic [15:0] since_q; // Whole etu since last leading edge
  logic        stat1_q, stat2_q;
  logic        rx_start, tx_start, gap_done;
  // Every start edge and every launch realigns the etu grid and the timeline,
  // otherwise a transmit would run on a stale half-etu count
  assign rx_start = (st_q == L_IDLE) && io_prev_q && !IO_IN;
  assign tx_start = (st_q == L_IDLE) && !rx_start && tx_busy_q && since_q >= `BGT_ETU;
  assign gap_done = (st_q == L_GAP) && hcnt_q > 16'h001B + `REPEAT_GAP_ETU;
  assign restart  = rx_start || tx_start || (gap_done && repeat_q);
  // Half-etu timeline of one character
  always_ff @(posedge CLK) begin
    if (SRST || restart) begin
      hcnt_q <= 16'h0000;
    end else if (etu.tick || etu.half) begin
      hcnt_q <= hcnt_q + 16'h0001;
    end
  end
  always_ff @(posedge CLK) begin
    if (SRST) begin
      io_prev_q <= 1'b1;
    end else begin
      io_prev_q <= IO_IN;
    end
  end
  // Line state machine: receive, transmit with repeat, gap after every transmit
  always_ff @(posedge CLK) begin
    if (SRST) begin
      st_q <= L_IDLE;
      sh_q <= 10'h3FF;
      rx_valid_q <= 1'b0;
      rx_perr_q <= 1'b0;
      rxd_q <= 8'h00;
      err_drive_q <= 1'b0;
      tx_busy_q <= 1'b0;
      repeat_q <= 1'b0;
      rx_last_q <= 1'b0;
      tx_last_q <= 1'b0;
    end else begin
      if (RD && ADDR == `RXD_OFS) begin
        rx_valid_q <= 1'b0;
      end
      case (st_q)
        L_IDLE: begin
          if (rx_start) begin
            st_q <= L_RX;
          end else if (tx_start) begin
            st_q <= L_TX;
            sh_q <= {par8(txd_q), txd_q, 1'b0};
          end
        end
        L_RX: begin
          if (etu.tick || etu.half) begin
            // Sample data at n+0.5 etu, bit ranks 2..10
            if (hcnt_q[0] == 1'b0 && hcnt_q >= 16'h0002 && hcnt_q <= 16'h0012) begin
              sh_q <= {IO_IN, sh_q[9:1]};
            end
            if (hcnt_q == `ERR_SAMPLE_HALF - 16'h0001) begin
              if (^sh_q[9:1] && !blockmode_q) begin
                err_drive_q <= 1'b1;
                rx_perr_q <= 1'b1;
              end else begin
                rxd_q <= sh_q[8:1];
                rx_valid_q <= 1'b1;
                rx_perr_q <= rx_perr_q | (^sh_q[9:1]);
                rx_last_q <= 1'b1;
                tx_last_q <= 1'b0;
              end
            end
            if (hcnt_q == `ERR_SAMPLE_HALF + 16'h0002) begin
              err_drive_q <= 1'b0;
              st_q <= L_IDLE;
            end
          end
        end
        L_TX: begin
          // Tenth shift at 10 etu frees the line before the 11 etu sample
          if (etu.tick && hcnt_q[0] == 1'b1 && hcnt_q <= 16'h0013) begin
            sh_q <= {1'b1, sh_q[9:1]};
          end
          if (etu.tick && hcnt_q == 16'h0015) begin
            repeat_q <= !IO_IN && !blockmode_q;
            tx_busy_q <= (!IO_IN && !blockmode_q);
            tx_last_q <= 1'b1;
            rx_last_q <= 1'b0;
            st_q <= L_GAP;
          end
        end
        L_GAP: begin
          // Repeat waits past the error pulse and starts 15 etu after the leading edge
          if (gap_done) begin
            st_q <= repeat_q ? L_TX : L_IDLE;
            sh_q <= {par8(txd_q), txd_q, 1'b0};
            repeat_q <= 1'b0;
          end
        end
        default: st_q <= L_IDLE;
      endcase
      // Software start wins over the end-of-character clear in the same cycle
      if (WR && ADDR == `TXD_OFS) begin
        tx_busy_q <= 1'b1;
      end
    end
  end
  // Drive low only for a zero bit or the error pulse
  assign IO_OUT = 1'b0;
  assign IO_OE_N = !((st_q == L_TX && !sh_q[0]) || err_drive_q);
  // Etu counter since the last character's leading edge
  always_ff @(posedge CLK) begin
    if (SRST || restart) begin
      since_q <= 16'h0000;
    end else if (etu.tick && since_q != 16'hFFFF) begin
      since_q <= since_q + 16'h0001;
    end
  end
  // Block receive framing and check byte
  sclink_pkg::blk_e   bst_q;
  sclink_pkg::btype_e btype_q;
  logic [7:0] lrc_q, left_q;
  logic       connected_q;
  logic       rx_byte;
  assign rx_byte = (st_q == L_RX) && (etu.tick || etu.half)
                   && hcnt_q == `ERR_SAMPLE_HALF - 16'h0001 && blockmode_q;
  always_ff @(posedge CLK) begin
    if (SRST || !blockmode_q) begin
      bst_q <= sclink_pkg::RX_NAD;
      lrc_q <= 8'h00;
      left_q <= 8'h00;
      edc_err_q <= 1'b0;
      addr_err_q <= 1'b0;
      len_err_q <= 1'b0;
      cwt_err_q <= 1'b0;
      connected_q <= 1'b0;
      addr_q <= 8'h00;
      btype_q <= sclink_pkg::BT_INFO;
    end else begin
      if (WR && ADDR == `STAT_OFS) begin
        edc_err_q <= 1'b0;
        addr_err_q <= 1'b0;
        len_err_q <= 1'b0;
        cwt_err_q <= 1'b0;
      end
      if (bst_q != sclink_pkg::RX_NAD && since_q > `CWT_BASE_ETU + (16'h0001 << cwi_q)) begin
        cwt_err_q <= 1'b1;
        bst_q <= sclink_pkg::RX_NAD;
      end else if (rx_byte) begin
        lrc_q <= lrc_q ^ sh_q[8:1];
        case (bst_q)
          sclink_pkg::RX_NAD: begin
            lrc_q <= sh_q[8:1];
            if (sh_q[8:1] != 8'h00) begin
              addr_err_q <= 1'b1;
            end
            if (!connected_q) begin
              addr_q <= sh_q[8:1];
              connected_q <= 1'b1;
            end
            bst_q <= sclink_pkg::RX_PCB;
          end
          sclink_pkg::RX_PCB: begin
            btype_q <= !sh_q[8] ? sclink_pkg::BT_INFO
                     : (!sh_q[7] ? sclink_pkg::BT_RDY : sclink_pkg::BT_SUP);
            bst_q <= sclink_pkg::RX_LEN;
          end
          sclink_pkg::RX_LEN: begin
            left_q <= sh_q[8:1];
            if (sh_q[8:1] == `LEN_RESERVED || sh_q[8:1] > card_max_info_length_q) begin
              len_err_q <= 1'b1;
            end
            bst_q <= (sh_q[8:1] == 8'h00) ? sclink_pkg::RX_EDC : sclink_pkg::RX_INF;
          end
          sclink_pkg::RX_INF: begin
            left_q <= left_q - 8'h01;
            if (left_q == 8'h01) begin
              bst_q <= sclink_pkg::RX_EDC;
            end
          end
          sclink_pkg::RX_EDC: begin
            if (lrc_q != sh_q[8:1]) begin
              edc_err_q <= 1'b1;
            end
            bst_q <= sclink_pkg::RX_NAD; // send right passes to card
          end
          default: bst_q <= sclink_pkg::RX_NAD;
        endcase
      end
    end
  end
  // Status-word tracking of the last two bytes sent, normal end is 90 00
  always_ff @(posedge CLK) begin
    if (SRST) begin
      stat1_q <= 1'b0;
      stat2_q <= 1'b0;
    end else if (WR && ADDR == `TXD_OFS) begin
      stat1_q <= (WDATA == `SW1_NORMAL);
      stat2_q <= stat1_q && (WDATA == `SW2_NORMAL);
    end
  end
  // Software configuration registers
  always_ff @(posedge CLK) begin
    if (SRST) begin
      blockmode_q <= 1'b0;
      txd_q <= 8'h00;
      cwi_q <= 4'h0;
      card_max_info_length_q <= `IFS_DEFAULT;
      etudiv_q <= `ETU_DEFAULT;
    end else if (WR) begin
      case (ADDR)
        `CTRL_OFS: blockmode_q <= WDATA[0];
        `TXD_OFS:  txd_q <= WDATA;
        `CWI_OFS: begin
          cwi_q <= (WDATA[3:0] > `CWI_MAX) ? `CWI_MAX : WDATA[3:0];
        end
        `CARD_MAX_INFO_LENGTH_OFS: begin
          card_max_info_length_q <= (WDATA > `IFS_MAX) ? `IFS_MAX : WDATA;
        end
        `ETU_OFS: etudiv_q <= {WDATA, 8'h00} | 16'h0001;
        default: begin
        end
      endcase
    end
  end
  assign status_q = {stat2_q, tx_busy_q, rx_valid_q, rx_perr_q,
                     edc_err_q, addr_err_q, len_err_q, cwt_err_q};
  // Read data in the cycle after the strobe
  always_ff @(posedge CLK) begin
    if (SRST) begin
      RDATA <= 8'h00;
    end else if (RD) begin
      case (ADDR)
        `ADDR_OFS: RDATA <= addr_q;
        `CTRL_OFS: RDATA <= {5'h00, btype_q, blockmode_q};
        `STAT_OFS: RDATA <= status_q;
        `CWI_OFS:  RDATA <= {4'h0, cwi_q};
        `CARD_MAX_INFO_LENGTH_OFS: RDATA <= card_max_info_length_q;
        `TXD_OFS:  RDATA <= txd_q;
        `RXD_OFS:  RDATA <= rxd_q;
        `ETU_OFS:  RDATA <= etudiv_q[15:8];
        default:   RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end
  // Checks
  err_pulse_len_a: assert property (@(posedge CLK) disable iff (SRST)
    $rose(err_drive_q) |-> err_drive_q [*2]) else $error("error pulse too short");
  guard_before_tx_a: assert property (@(posedge CLK) disable iff (SRST)
    (st_q == L_IDLE && $past(st_q) == L_IDLE) ##1 st_q == L_TX |-> $past(since_q) >= `BGT_ETU)
    else $error("transmit before guard time");
  cwi_range_a: assert property (@(posedge CLK) disable iff (SRST)
    cwi_q <= `CWI_MAX) else $error("char wait integer out of range");
  ifs_range_a: assert property (@(posedge CLK) disable iff (SRST)
    card_max_info_length_q <= `IFS_MAX) else $error("info length above limit");
  no_drive_idle_a: assert property (@(posedge CLK) disable iff (SRST)
    st_q == L_IDLE |-> IO_OE_N) else $error("line driven while idle");
  repeat_delay_a: assert property (@(posedge CLK) disable iff (SRST)
    $past(st_q) == L_GAP && st_q == L_TX |-> $past(hcnt_q) >= 16'h001C)
    else $error("repeat sent too early");
  tx_cover_c: cover property (@(posedge CLK) st_q == L_TX);
  repeat_cover_c: cover property (@(posedge CLK) repeat_q && st_q == L_GAP);
  edc_cover_c: cover property (@(posedge CLK) edc_err_q);
endmodule
`default_nettype wire

// File: testbench/sclink_term.sv
`timescale 1ns/100ps
`default_nettype none
// Terminal side of the I/O line; pull high means this side drives the line low
module sclink_term #(
  parameter int E = 257
) (
  // Clock
  input  wire logic CLK,
  // Line level and pull-down
  input  wire logic line,
  output var logic  pull
);
  int         cyc = 0;
  int         last_tx = 0;
  int         perr = 0;
  bit         tx_on = 1'b0;
  bit         nack = 1'b0;
  logic [7:0] rx_q[$];
  int         rx_t[$];
  logic [8:0] b;
  initial pull = 1'b0;
  // Free cycle count, the time base of every gap check
  always @(posedge CLK) cyc <= cyc + 1;
  // Receiver samples mid-bit; ends at 12 etu so a 12 etu spacing is not missed
  always begin
    @(posedge CLK);
    if (!tx_on && line === 1'b0) begin
      rx_t.push_back(cyc);
      repeat (E / 2) @(posedge CLK);
      for (int i = 0; i < 9; i++) begin
        repeat (E) @(posedge CLK);
        b[i] = line;
      end
      if (^b !== 1'b0) perr++;
      rx_q.push_back(b[7:0]);
      repeat (E) @(posedge CLK);
      // Error pulse from 10.5 to 12 etu when asked to refuse a character
      pull <= nack;
      repeat (E + E / 2) @(posedge CLK);
      pull <= 1'b0;
      nack = 1'b0;
    end
  end
  // Send one character, then report the low time seen from 10 etu on
  task automatic send_char(input logic [7:0] d, input bit bad,
                           output int lo, output int first);
    logic [9:0] f;
    f = {^d ^ bad, d, 1'b0};
    lo = 0;
    first = 0;
    tx_on = 1'b1;
    last_tx = cyc;
    for (int i = 0; i < 10; i++) begin
      pull <= ~f[i];
      repeat (E) @(posedge CLK);
    end
    pull <= 1'b0;
    // Watch for the error pulse around the 11 etu sample point
    for (int k = 0; k < 5 * E / 2; k++) begin
      @(posedge CLK);
      if (line === 1'b0) begin
        if (lo == 0) first = k;
        lo++;
      end
    end
    tx_on = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: testbench/smartcard_link_layer_test.sv
`timescale 1ns/100ps
`default_nettype none
module smartcard_link_layer_test;
  localparam int E = 257;
  logic       clk;
  logic       srst;
  logic [4:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  logic       io_out;
  logic       io_oe_n;
  logic       pull;
  wire        line;
  int         failures = 0;
  int         checks_done = 0;
  int         lo;
  int         first;
  logic [7:0] v;
  logic [7:0] nads[4] = '{8'h00, 8'h00, 8'h00, 8'h11};
  logic [7:0] pcbs[4] = '{8'h00, 8'h80, 8'hC1, 8'h00};
  logic       bads[4] = '{1'b0, 1'b0, 1'b0, 1'b1};
  logic [7:0] errs[4] = '{8'h00, 8'h00, 8'h00, 8'h0C};
  logic [7:0] ctls[3] = '{8'h01, 8'h03, 8'h05};
  // Open-drain line with pull-up: low while either side pulls
  assign line = ~(pull | (io_oe_n === 1'b0 && io_out === 1'b0));
  sclink_top sclink_top_inst (
    .CLK    (clk),
    .SRST   (srst),
    .ADDR   (addr),
    .WDATA  (wdata),
    .WR     (wr),
    .RD     (rd),
    .RDATA  (rdata),
    .IO_IN  (line),
    .IO_OUT (io_out),
    .IO_OE_N(io_oe_n)
  );
  sclink_term #(.E(E)) sclink_term_inst (.CLK(clk), .line(line), .pull(pull));
  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic tally_and_finish();
    $display("checks_done=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic wrr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [4:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  task automatic rchk(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
    rd_reg(a);
    chk(v & m, e);
  endtask
  // Poll the busy flag; a hang counts as a mismatch
  task automatic wait_tx();
    int n;
    n = 0;
    repeat (8) @(posedge clk);
    rd_reg(5'h08);
    while (v[6] !== 1'b0) begin
      n++;
      if (n > 8000) begin
        failures++;
        tally_and_finish();
      end
      rd_reg(5'h08);
    end
    repeat (2 * E) @(posedge clk);
  endtask
  // Empty block: address, control, zero length, xor check byte
  task automatic blk(input logic [7:0] node_address_byte, input logic [7:0] protocol_control_byte, input logic bad);
    logic [7:0] f[4];
    f = '{node_address_byte, protocol_control_byte, 8'h00, node_address_byte ^ protocol_control_byte ^ {7'h00, bad}};
    for (int i = 0; i < 4; i++) sclink_term_inst.send_char(f[i], 1'b0, lo, first);
  endtask
  initial begin
    srst = 1'b1;
    addr = 5'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    rchk(5'h1C, 8'hFF, 8'h01);
    // Read data must drop back to zero one cycle later
    @(posedge clk);
    #1;
    chk(rdata, 8'h00);
    rchk(5'h10, 8'hFF, 8'h20);
    rchk(5'h03, 8'hFF, 8'h00);
    wrr(5'h10, 8'hFF);
    rchk(5'h10, 8'hFF, 8'hFE);
    wrr(5'h0C, 8'h09);
    rchk(5'h0C, 8'hFF, 8'h05);
    wrr(5'h1C, 8'h01);
    // Character mode: bad parity is refused, the repeat is taken
    sclink_term_inst.send_char(8'h3C, 1'b1, lo, first);
    chk(lo >= E && lo <= 2 * E, 1'b1);
    chk(first >= E / 2 - E / 5 && first <= E / 2 + E / 5, 1'b1);
    sclink_term_inst.send_char(8'h3C, 1'b0, lo, first);
    chk(lo, 0);
    rchk(5'h18, 8'hFF, 8'h3C);
    // Refused transmit must be sent again
    sclink_term_inst.nack = 1'b1;
    wrr(5'h14, 8'hA5);
    wait_tx();
    chk({sclink_term_inst.rx_q[0], sclink_term_inst.rx_q[1]}, 16'hA5A5);
    wrr(5'h14, 8'h90);
    wait_tx();
    wrr(5'h14, 8'h00);
    wait_tx();
    chk({sclink_term_inst.rx_q[2], sclink_term_inst.rx_q[3]}, 16'h9000);
    rchk(5'h08, 8'h80, 8'h80);
    // Block mode: one block per type, then a bad address with a bad check byte
    // Keep the guard time after the last card character before the first block
    repeat (10 * E) @(posedge clk);
    wrr(5'h04, 8'h01);
    for (int i = 0; i < 4; i++) begin
      blk(nads[i], pcbs[i], bads[i]);
      rchk(5'h08, 8'h0F, errs[i]);
      if (i < 3) rchk(5'h04, 8'h07, ctls[i]);
      wrr(5'h08, 8'hFF);
      if (i == 0) begin
        rchk(5'h00, 8'hFF, 8'h00);
        wrr(5'h14, 8'h55);
        wait_tx();
        chk(sclink_term_inst.rx_q[$], 8'h55);
        chk(sclink_term_inst.rx_t[$] - sclink_term_inst.last_tx >= 22 * E, 1'b1);
        repeat (10 * E) @(posedge clk);
      end
    end
    chk(sclink_term_inst.perr, 0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
